// ---- rtl/tvp_consts.vh ----
/*
  Constants for the television PWM duty data register bank: register
  indices, byte addresses, field layouts, reset values and counter sizes.
  Assumes it is included by bare name from the bank's design files.
*/
`ifndef TVP_CONSTS_VH
`define TVP_CONSTS_VH

// ***************************************************************
// Register indices (byte address is four times the index, plus 100h for the channel 6 pair)
// ***************************************************************
`define TVP_IDX_CH11_HI    8'h00
`define TVP_IDX_CH11_LO    8'h01
`define TVP_IDX_CH5        8'h06
`define TVP_IDX_CH10       8'h0B
`define TVP_IDX_CH6_HI     8'h08
`define TVP_IDX_CH6_LO     8'h09
`define TVP_IDX_MODE       8'h0D

// ***************************************************************
// Byte addresses on the register bus
// ***************************************************************
`define TVP_AW             10
`define TVP_BANKF_BASE     10'h100
`define TVP_ADDR_STATUS    10'h200
`define TVP_ADDR_CH11_HI   {`TVP_IDX_CH11_HI, 2'b00}
`define TVP_ADDR_CH11_LO   {`TVP_IDX_CH11_LO, 2'b00}
`define TVP_ADDR_MODE      {`TVP_IDX_MODE, 2'b00}
`define TVP_ADDR_CH6_HI    (`TVP_BANKF_BASE | {`TVP_IDX_CH6_HI, 2'b00})
`define TVP_ADDR_CH6_LO    (`TVP_BANKF_BASE | {`TVP_IDX_CH6_LO, 2'b00})

// ***************************************************************
// Fields, reset values and bus answers
// ***************************************************************
`define TVP_MODE_BIT       7
`define TVP_DUTY_RST       6'h00
`define TVP_LOW_RST        8'h00
`define TVP_DUTY_MAX       6'h3F
`define TVP_RESP_OKAY      2'b00
`define TVP_RESP_SLVERR    2'b10

// ***************************************************************
// Counter sizes
// ***************************************************************
`define TVP_PRE_LAST       4'hF
`define TVP_CNT6_LAST      6'h3F
`define TVP_CNT14_TOP      14'h3FFF
`define TVP_CNT14_END      14'h0000
`define TVP_POS_TOP        7'h7F

`endif

// ---- rtl/tvp_chan6.v ----
/*
  One 6-bit PWM channel: holds the duty value in use for the running
  period and drives the registered output.
  Assumes the shared counters and period-end strobe come from the same clock.
*/
`timescale 1ns/1ps
`include "tvp_consts.vh"

module tvp_chan6 #(
  parameter W = 6
) (
  input  wire         i_clk,
  input  wire         i_rst_n,
  input  wire [W-1:0] i_duty,
  input  wire [W-1:0] i_cnt,
  input  wire         i_period_end,
  output reg          o_pwm,
  output reg  [W-1:0] o_active
);

  // ***************************************************************
  // Period-aligned duty and output
  // ***************************************************************
  reg [W-1:0] nxt_active;
  reg         nxt_pwm;

  // New duty only at the period boundary so no pulse is cut or doubled
  always @* begin
    nxt_active = o_active;
    if (i_period_end) begin
      nxt_active = i_duty;
    end
    nxt_pwm = (o_active == `TVP_DUTY_MAX) | (i_cnt < o_active);
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_active <= `TVP_DUTY_RST;
      o_pwm    <= 1'b0;
    end else begin
      o_active <= nxt_active;
      o_pwm    <= nxt_pwm;
    end
  end

endmodule // tvp_chan6

// ---- rtl/tvp_pwm_bank.v ----
/*
  Duty data register bank for PWM channels 5 to 11 with its generators.
  Holds the 6-bit duty registers of channels 5 to 10, the split 14-bit
  ratio registers of channels 6 and 11, the channel 6 width select, and
  an AXI4-Lite slave through which software reaches them all.
  Assumes i_clk is the crystal clock and the outputs feed RC integrators
  through pin multiplexers that live elsewhere.
*/
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "tvp_consts.vh"

module tvp_pwm_bank #(
  parameter AW = `TVP_AW
) (
  input  wire          i_clk,
  input  wire          i_rst_n,
  // AXI4-Lite write address
  input  wire          i_axi_awvalid,
  output wire          o_axi_awready,
  input  wire [AW-1:0] i_axi_awaddr,
  input  wire [2:0]    i_axi_awprot,
  // AXI4-Lite write data
  input  wire          i_axi_wvalid,
  output wire          o_axi_wready,
  input  wire [31:0]   i_axi_wdata,
  input  wire [3:0]    i_axi_wstrb,
  // AXI4-Lite write response
  output reg           o_axi_bvalid,
  input  wire          i_axi_bready,
  output reg  [1:0]    o_axi_bresp,
  // AXI4-Lite read address
  input  wire          i_axi_arvalid,
  output wire          o_axi_arready,
  input  wire [AW-1:0] i_axi_araddr,
  input  wire [2:0]    i_axi_arprot,
  // AXI4-Lite read data
  output reg           o_axi_rvalid,
  input  wire          i_axi_rready,
  output reg  [31:0]   o_axi_rdata,
  output reg  [1:0]    o_axi_rresp,
  // PWM outputs
  output wire          o_ch5_pwm,
  output reg           o_ch6_pwm,
  output wire          o_ch7_pwm,
  output wire          o_ch8_pwm,
  output wire          o_ch9_pwm,
  output wire          o_ch10_pwm,
  output reg           o_ch11_pwm
);

  // Channels 5 to 10 share one generator design
  localparam NCH = 6;

  // ***************************************************************
  // Software-visible storage
  // ***************************************************************
  reg [6*NCH-1:0] duty_ff;        // Channels 5..10, six bits each
  reg [5:0]       ch6_hi_ff;
  reg [7:0]       ch6_lo_ff;
  reg [5:0]       ch11_hi_ff;
  reg [7:0]       ch11_lo_ff;
  reg             mode14_ff;

  // ***************************************************************
  // Shared timebase
  // ***************************************************************
  reg  [3:0]  pre_ff;
  reg  [5:0]  cnt6_ff;
  reg  [13:0] cnt14_ff;
  wire        tick6;
  wire        end6;
  wire        end14;

  // Divide by 16, then count 64 steps for the 6-bit period
  assign tick6 = (pre_ff == `TVP_PRE_LAST);
  assign end6  = tick6 & (cnt6_ff == `TVP_CNT6_LAST);
  assign end14 = (cnt14_ff == `TVP_CNT14_END);

  // Counters free-run from reset so every channel shares one phase
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      pre_ff   <= 4'h0;
      cnt6_ff  <= 6'h00;
      cnt14_ff <= `TVP_CNT14_TOP;
    end else begin
      pre_ff <= pre_ff + 4'h1;
      if (tick6) begin
        cnt6_ff <= cnt6_ff + 6'h01;
      end
      // 14-bit down counter wraps from 0 back to 3FFFh
      if (end14) begin
        cnt14_ff <= `TVP_CNT14_TOP;
      end else begin
        cnt14_ff <= cnt14_ff - 14'h0001;
      end
    end
  end

  // ***************************************************************
  // 6-bit channels 5..10
  // ***************************************************************
  wire [NCH-1:0]   ch6_duty_short;

  // One generator per channel; the period-aligned duty stays inside it
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      tvp_chan6 #(
        .W (6)
      ) u_chan (
        .i_clk        (i_clk),
        .i_rst_n      (i_rst_n),
        .i_duty       (duty_ff[6*g +: 6]),
        .i_cnt        (cnt6_ff),
        .i_period_end (end6),
        .o_pwm        (ch6_duty_short[g]),
        .o_active     ()
      );
    end
  endgenerate

  // Channel 6 leaves the row here: its pin follows the width select
  assign o_ch5_pwm  = ch6_duty_short[0];
  assign o_ch7_pwm  = ch6_duty_short[2];
  assign o_ch8_pwm  = ch6_duty_short[3];
  assign o_ch9_pwm  = ch6_duty_short[4];
  assign o_ch10_pwm = ch6_duty_short[5];

  // ***************************************************************
  // 14-bit channels 6 and 11
  // ***************************************************************
  // Ratios in use for the running 14-bit period
  reg [13:0] ch6_ratio_ff;
  reg [13:0] ch11_ratio_ff;

  // Bit-reversed slot number spreads the extra pulses evenly
  function [6:0] rev7;
    input [6:0] v;
    integer k;
    begin
      for (k = 0; k < 7; k = k + 1) begin
        rev7[k] = v[6-k];
      end
    end
  endfunction

  // Base pulse from bits 13..7, one extra step from bits 6..0
  // Limitation: the extra clock always sits at the end of the base pulse
  function gen14;
    input [13:0] ratio;
    input [13:0] cnt;
    reg   [6:0]  pos;
    begin
      pos   = `TVP_POS_TOP - cnt[6:0];
      gen14 = (pos < ratio[13:7]) |
              ((pos == ratio[13:7]) & (rev7(cnt[13:7]) < ratio[6:0]));
    end
  endfunction

  // Both bytes are taken together at the period end, so a ratio never changes mid-period
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      ch6_ratio_ff  <= 14'h0000;
      ch11_ratio_ff <= 14'h0000;
      o_ch6_pwm     <= 1'b0;
      o_ch11_pwm    <= 1'b0;
    end else begin
      if (end14) begin
        ch6_ratio_ff  <= {ch6_hi_ff, ch6_lo_ff};
        ch11_ratio_ff <= {ch11_hi_ff, ch11_lo_ff};
      end
      if (mode14_ff) begin
        o_ch6_pwm <= gen14(ch6_ratio_ff, cnt14_ff);
      end else begin
        o_ch6_pwm <= ch6_duty_short[1];
      end
      o_ch11_pwm <= gen14(ch11_ratio_ff, cnt14_ff);
    end
  end

  // ***************************************************************
  // AXI4-Lite write path
  // ***************************************************************
  reg          aw_hold_ff;
  reg          w_hold_ff;
  reg [AW-1:0] waddr_ff;
  reg [7:0]    wbyte_ff;
  reg          wlane_ff;
  wire         do_write;
  wire         wmapped;
  wire [AW-1:0] b_lo;
  wire [AW-1:0] b_hi;

  // Address and data are taken in either order, one write at a time
  assign o_axi_awready = ~aw_hold_ff & ~o_axi_bvalid;
  assign o_axi_wready  = ~w_hold_ff & ~o_axi_bvalid;
  assign do_write      = aw_hold_ff & w_hold_ff & ~o_axi_bvalid;
  assign b_lo          = {`TVP_IDX_CH5, 2'b00};
  assign b_hi          = {`TVP_IDX_CH10, 2'b00};

  // Status is mapped for reads; a write to it answers OKAY and changes nothing
  function mapped;
    input [AW-1:0] a;
    begin
      mapped = (a == `TVP_ADDR_CH11_HI) | (a == `TVP_ADDR_CH11_LO) |
               (a == `TVP_ADDR_MODE) | (a == `TVP_ADDR_CH6_HI) |
               (a == `TVP_ADDR_CH6_LO) | (a == `TVP_ADDR_STATUS) |
               ((a >= {`TVP_IDX_CH5, 2'b00}) & (a <= {`TVP_IDX_CH10, 2'b00}) &
                (a[1:0] == 2'b00));
    end
  endfunction

  // Decoded from the held address so the answer matches the store
  assign wmapped = mapped(waddr_ff);

  // Channels are held until both are in, then answered once
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      aw_hold_ff   <= 1'b0;
      w_hold_ff    <= 1'b0;
      waddr_ff     <= {AW{1'b0}};
      wbyte_ff     <= 8'h00;
      wlane_ff     <= 1'b0;
      o_axi_bvalid <= 1'b0;
      o_axi_bresp  <= `TVP_RESP_OKAY;
    end else begin
      if (o_axi_awready & i_axi_awvalid) begin
        aw_hold_ff <= 1'b1;
        waddr_ff   <= i_axi_awaddr;
      end
      if (o_axi_wready & i_axi_wvalid) begin
        w_hold_ff <= 1'b1;
        wbyte_ff  <= i_axi_wdata[7:0];
        wlane_ff  <= i_axi_wstrb[0];
      end
      if (do_write) begin
        aw_hold_ff   <= 1'b0;
        w_hold_ff    <= 1'b0;
        o_axi_bvalid <= 1'b1;
        o_axi_bresp  <= wmapped ? `TVP_RESP_OKAY : `TVP_RESP_SLVERR;
      end else if (o_axi_bvalid & i_axi_bready) begin
        o_axi_bvalid <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Register writes
  // ***************************************************************
  wire       wr_en;
  wire [3:0] wslot;
  wire [7:0] wslot_wide;

  // A write with byte lane 0 off is answered but stores nothing
  // Slot is reckoned at index width and cut to the four bits a slot needs
  assign wr_en      = do_write & wlane_ff;
  assign wslot_wide = {4'h0, waddr_ff[5:2]} - `TVP_IDX_CH5;
  assign wslot      = wslot_wide[3:0];

  // Only the value bits are stored; reserved bits ignore writes
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      duty_ff    <= {NCH{`TVP_DUTY_RST}};
      ch6_hi_ff  <= `TVP_DUTY_RST;
      ch11_hi_ff <= `TVP_DUTY_RST;
      ch6_lo_ff  <= `TVP_LOW_RST;
      ch11_lo_ff <= `TVP_LOW_RST;
      mode14_ff  <= 1'b0;
    end else if (wr_en) begin
      if (waddr_ff == `TVP_ADDR_CH11_HI) begin
        ch11_hi_ff <= wbyte_ff[5:0];
      end
      if (waddr_ff == `TVP_ADDR_CH11_LO) begin
        ch11_lo_ff <= wbyte_ff;
      end
      if (waddr_ff == `TVP_ADDR_CH6_HI) begin
        ch6_hi_ff <= wbyte_ff[5:0];
      end
      if (waddr_ff == `TVP_ADDR_CH6_LO) begin
        ch6_lo_ff <= wbyte_ff;
      end
      if (waddr_ff == `TVP_ADDR_MODE) begin
        mode14_ff <= wbyte_ff[`TVP_MODE_BIT];
      end
      if ((waddr_ff >= b_lo) & (waddr_ff <= b_hi) & (waddr_ff[1:0] == 2'b00)) begin
        duty_ff[6*wslot +: 6] <= wbyte_ff[5:0];
      end
    end
  end

  // ***************************************************************
  // AXI4-Lite read path
  // ***************************************************************
  reg  [31:0] nxt_rdata;
  wire [3:0]  rslot;
  wire [7:0]  rslot_wide;
  wire [31:0] status_word;

  // One read in flight: a new address waits until the data is taken
  assign o_axi_arready = ~o_axi_rvalid;
  assign rslot_wide    = {4'h0, i_axi_araddr[5:2]} - `TVP_IDX_CH5;
  assign rslot         = rslot_wide[3:0];

  // Live counters and pin levels, packed to the status layout
  assign status_word = {2'b00, cnt6_ff, 2'b00, cnt14_ff, 1'b0,
                        o_ch11_pwm, o_ch6_pwm, ch6_duty_short[5], ch6_duty_short[4],
                        ch6_duty_short[3], ch6_duty_short[2], ch6_duty_short[0]};

  // Reserved bits read as zero; status shows the live counters
  always @* begin
    nxt_rdata = 32'h0000_0000;
    if ((i_axi_araddr >= b_lo) & (i_axi_araddr <= b_hi)) begin
      nxt_rdata[5:0] = duty_ff[6*rslot +: 6];
    end
    case (i_axi_araddr)
      `TVP_ADDR_CH11_HI: nxt_rdata[5:0] = ch11_hi_ff;
      `TVP_ADDR_CH11_LO: nxt_rdata[7:0] = ch11_lo_ff;
      `TVP_ADDR_CH6_HI:  nxt_rdata[5:0] = ch6_hi_ff;
      `TVP_ADDR_CH6_LO:  nxt_rdata[7:0] = ch6_lo_ff;
      `TVP_ADDR_MODE:    nxt_rdata[`TVP_MODE_BIT] = mode14_ff;
      `TVP_ADDR_STATUS:  nxt_rdata = status_word;
      default:           nxt_rdata = nxt_rdata;
    endcase
  end

  // Data is registered at the address edge and held until rready
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_axi_rvalid <= 1'b0;
      o_axi_rdata  <= 32'h0000_0000;
      o_axi_rresp  <= `TVP_RESP_OKAY;
    end else if (o_axi_arready & i_axi_arvalid) begin
      o_axi_rvalid <= 1'b1;
      o_axi_rdata  <= mapped(i_axi_araddr) ? nxt_rdata : 32'h0000_0000;
      o_axi_rresp  <= mapped(i_axi_araddr) ? `TVP_RESP_OKAY : `TVP_RESP_SLVERR;
    end else if (o_axi_rvalid & i_axi_rready) begin
      o_axi_rvalid <= 1'b0;
    end
  end

endmodule // tvp_pwm_bank

// ---- verif/tvp_pwm_bank_props.sv ----
/*
  Checker for the PWM bank: register bus handshakes, answers and reset.
  Assumes it is bound to tvp_pwm_bank and sees only its ports.
*/
`timescale 1ns/1ps
`include "tvp_consts.vh"
module tvp_pwm_bank_props #(
  parameter AW = 10
) (
  input wire          i_clk,
  input wire          i_rst_n,
  input wire          i_axi_awvalid,
  input wire          o_axi_awready,
  input wire [AW-1:0] i_axi_awaddr,
  input wire          i_axi_wvalid,
  input wire          o_axi_wready,
  input wire          o_axi_bvalid,
  input wire          i_axi_bready,
  input wire [1:0]    o_axi_bresp,
  input wire          i_axi_arvalid,
  input wire          o_axi_arready,
  input wire [AW-1:0] i_axi_araddr,
  input wire          o_axi_rvalid,
  input wire          i_axi_rready,
  input wire [31:0]   o_axi_rdata,
  input wire [1:0]    o_axi_rresp,
  input wire          o_ch5_pwm
);
  // ****************************************
  // Helper logic
  // ****************************************
  reg  [AW-1:0] aw_addr_ff;
  reg  [AW-1:0] ar_addr_ff;
  reg           aw_got_ff;
  reg           w_got_ff;
  wire          aw_hs = i_axi_awvalid && o_axi_awready;
  wire          w_hs  = i_axi_wvalid && o_axi_wready;
  wire          both  = (aw_hs || aw_got_ff) && (w_hs || w_got_ff);

  // Mapped addresses, status included
  function automatic logic mapped(input logic [AW-1:0] a);
    case (a)
      10'h000, 10'h004, 10'h018, 10'h01C, 10'h020, 10'h024, 10'h028, 10'h02C,
      10'h034, 10'h120, 10'h124, 10'h200: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // Registers whose top two bits are reserved
  function automatic logic six(input logic [AW-1:0] a);
    six = (a == 10'h000) || (a == 10'h120) || (a >= 10'h018 && a <= 10'h02C);
  endfunction

  // Addresses kept so answers can be tied to the request that caused them
  always @(posedge i_clk) begin
    if (aw_hs) aw_addr_ff <= i_axi_awaddr;
    if (i_axi_arvalid && o_axi_arready) ar_addr_ff <= i_axi_araddr;
    aw_got_ff <= i_rst_n && !both && (aw_got_ff || aw_hs);
    w_got_ff  <= i_rst_n && !both && (w_got_ff || w_hs);
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // ****************************************
  // Assertions
  // ****************************************
  chk_b_after_write: assert property (both |-> ##[1:3] o_axi_bvalid)
    else $error("write response missing");
  chk_r_after_ar: assert property ((i_axi_arvalid && o_axi_arready) |=> o_axi_rvalid)
    else $error("read data missing");
  chk_r_hold: assert property (o_axi_rvalid && !i_axi_rready |=>
    o_axi_rvalid && $stable(o_axi_rdata) && $stable(o_axi_rresp)) else $error("read not held");
  chk_b_hold: assert property (o_axi_bvalid && !i_axi_bready |=>
    o_axi_bvalid && $stable(o_axi_bresp)) else $error("response not held");
  chk_ar_block: assert property (o_axi_rvalid |-> !o_axi_arready)
    else $error("read accepted while busy");
  chk_aw_block: assert property (o_axi_bvalid |-> !o_axi_awready && !o_axi_wready)
    else $error("write accepted while busy");
  chk_rdata_top: assert property (o_axi_rvalid && ar_addr_ff != `TVP_ADDR_STATUS |->
    o_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
  chk_reserved_bits: assert property (o_axi_rvalid && six(ar_addr_ff) |->
    o_axi_rdata[7:6] == 2'b00) else $error("reserved bits read nonzero");
  chk_rresp_code: assert property (o_axi_rvalid |-> o_axi_rresp ==
    (mapped(ar_addr_ff) ? `TVP_RESP_OKAY : `TVP_RESP_SLVERR)) else $error("bad read resp");
  chk_bresp_code: assert property (o_axi_bvalid |-> o_axi_bresp ==
    (mapped(aw_addr_ff) ? `TVP_RESP_OKAY : `TVP_RESP_SLVERR)) else $error("bad write resp");
  chk_reset_idle: assert property (disable iff (1'b0) !i_rst_n |=>
    !o_axi_bvalid && !o_axi_rvalid && !o_ch5_pwm) else $error("outputs busy in reset");
endmodule // tvp_pwm_bank_props

// ---- verif/tvp_rc_model.sv ----
/*
  RC integrator on one PWM pin: sums high cycles over a window.
  Assumes a start pulse of one cycle on the same clock as the pin.
*/
`timescale 1ns/1ps
module tvp_rc_model (
  input  wire        i_clk,
  input  wire        i_pin,
  input  wire        i_start,
  input  wire [15:0] i_len,
  output reg  [15:0] o_high,
  output reg         o_done
);
  reg [15:0] left_ff = 16'h0000;
  initial o_done = 1'b0;
  // Charge counts as the integral; the window length sets the averaging span
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    if (i_start) begin
      left_ff <= i_len;
      o_high  <= 16'h0000;
    end else if (left_ff != 16'h0000) begin
      left_ff <= left_ff - 16'h0001;
      o_high  <= o_high + {15'h0000, i_pin};
      o_done  <= (left_ff == 16'h0001);
    end
  end
endmodule // tvp_rc_model

// ---- verif/tvp_pwm_bank_tb.sv ----
/*
  Self-checking bench for the PWM bank: register access over AXI4-Lite
  and duty measured through RC models. Assumes the 125 MHz clock is the crystal.
*/
`timescale 1ns/1ps
`include "tvp_consts.vh"
module tvp_pwm_bank_tb;
  logic        clk = 1'b0, rst_n = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [9:0]  awaddr = 10'h000, araddr = 10'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  wire         awready, wready, bvalid, arready, rvalid, done_a, done_b;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [6:0]   pwm;
  wire [15:0]  high_a, high_b;
  logic [2:0]  sel = 3'h0;
  logic        start_a = 1'b0, start_b = 1'b0;
  logic [15:0] len = 16'h0400;
  int          failures = 0, total_checks = 0, seed = 35394, i;
  logic [7:0]  d;
  logic [7:0]  val [0:10];
  logic [13:0] r6, r11;
  logic [5:0]  dut [0:5] = '{6'h00, 6'h3F, 6'h01, 6'h00, 6'h20, 6'h3E};
  logic [9:0]  adr [0:10] = '{10'h000, 10'h004, 10'h018, 10'h01C, 10'h020, 10'h024,
                              10'h028, 10'h02C, 10'h120, 10'h124, 10'h034};
  logic [7:0]  msk [0:10] = '{8'h3F, 8'hFF, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h3F,
                              8'h3F, 8'hFF, 8'h80};
  logic [33:0] exp_rd [$];
  logic [1:0]  exp_b [$];
  logic [15:0] exp_pwm [$];

  always #4 clk = ~clk;

  tvp_pwm_bank uut (.i_clk(clk), .i_rst_n(rst_n), .i_axi_awvalid(awvalid),
    .o_axi_awready(awready), .i_axi_awaddr(awaddr), .i_axi_awprot(3'h0),
    .i_axi_wvalid(wvalid), .o_axi_wready(wready), .i_axi_wdata(wdata), .i_axi_wstrb(wstrb),
    .o_axi_bvalid(bvalid), .i_axi_bready(bready), .o_axi_bresp(bresp),
    .i_axi_arvalid(arvalid), .o_axi_arready(arready), .i_axi_araddr(araddr),
    .i_axi_arprot(3'h0), .o_axi_rvalid(rvalid), .i_axi_rready(rready), .o_axi_rdata(rdata),
    .o_axi_rresp(rresp), .o_ch5_pwm(pwm[0]), .o_ch6_pwm(pwm[1]), .o_ch7_pwm(pwm[2]),
    .o_ch8_pwm(pwm[3]), .o_ch9_pwm(pwm[4]), .o_ch10_pwm(pwm[5]), .o_ch11_pwm(pwm[6]));
  tvp_rc_model u_rc_a (.i_clk(clk), .i_pin(pwm[sel]), .i_start(start_a), .i_len(len),
    .o_high(high_a), .o_done(done_a));
  tvp_rc_model u_rc_b (.i_clk(clk), .i_pin(pwm[6]), .i_start(start_b), .i_len(len),
    .o_high(high_b), .o_done(done_b));

  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Handshakes are sampled mid-cycle so the result never races the edge
  task automatic wr(input logic [9:0] a, input logic [7:0] dd, input logic [3:0] s,
                    input logic [1:0] eb);
    logic ah, wh, bh;
    exp_b.push_back(eb);
    @(posedge clk);
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    awaddr <= a; wdata <= {24'h0, dd}; wstrb <= s;
    do begin
      @(negedge clk);
      ah = awvalid && awready; wh = wvalid && wready; bh = bready && bvalid;
      @(posedge clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) bready <= 1'b0;
    end while (!bh);
  endtask

  task automatic rd(input logic [9:0] a, input logic [33:0] e);
    logic ah, rh;
    exp_rd.push_back(e);
    @(posedge clk);
    arvalid <= 1'b1; rready <= 1'b1; araddr <= a;
    do begin
      @(negedge clk);
      ah = arvalid && arready; rh = rready && rvalid;
      @(posedge clk);
      if (ah) arvalid <= 1'b0;
      if (rh) rready <= 1'b0;
    end while (!rh);
  endtask

  task automatic meas(input logic [2:0] s, input logic [15:0] ln, input logic [15:0] ea,
                      input logic [15:0] eb, input logic two);
    exp_pwm.push_back(ea);
    if (two) exp_pwm.push_back(eb);
    @(posedge clk);
    sel <= s; len <= ln; start_a <= 1'b1; start_b <= two;
    @(posedge clk);
    start_a <= 1'b0; start_b <= 1'b0;
    repeat (ln + 4) @(posedge clk);
  endtask

  task automatic finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Results are matched in arrival order against the notes of the drivers
  always @(negedge clk) begin
    if (rvalid && rready) check("rdata", {rresp, rdata}, exp_rd.pop_front());
    if (bvalid && bready) check("bresp", {32'h0, bresp}, {32'h0, exp_b.pop_front()});
    if (done_a) check("pwm_a", {18'h0, high_a}, {18'h0, exp_pwm.pop_front()});
    if (done_b) check("pwm_b", {18'h0, high_b}, {18'h0, exp_pwm.pop_front()});
  end

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    finish_test();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 11; i++) rd(adr[i], {`TVP_RESP_OKAY, 32'h0});
    $display("test reset_values done");
    for (i = 0; i < 11; i++) begin
      d = $random(seed) | 8'hC0;
      val[i] = d & msk[i];
      wr(adr[i], d, 4'h1, `TVP_RESP_OKAY);
      rd(adr[i], {`TVP_RESP_OKAY, 24'h0, val[i]});
    end
    wr(adr[2], 8'h15, 4'h0, `TVP_RESP_OKAY);
    rd(adr[2], {`TVP_RESP_OKAY, 24'h0, val[2]});
    wr(10'h3FC, 8'hAA, 4'h1, `TVP_RESP_SLVERR);
    rd(10'h3FC, {`TVP_RESP_SLVERR, 32'h0});
    rd(10'h104, {`TVP_RESP_SLVERR, 32'h0});
    $display("test register_access done");
    dut[3] = $random(seed);
    wr(adr[10], 8'h00, 4'h1, `TVP_RESP_OKAY);
    for (i = 0; i < 6; i++) wr(adr[2 + i], {2'b00, dut[i]}, 4'h1, `TVP_RESP_OKAY);
    repeat (1100) @(posedge clk);
    // Each counter step lasts sixteen clocks, so a period holds 16 x duty high clocks, or all 1024 at duty 3Fh
    for (i = 0; i < 6; i++) meas(i, 16'd1024,
                                 (dut[i] == `TVP_DUTY_MAX) ? 16'd1024 : {6'h00, dut[i], 4'h0},
                                 16'h0, 1'b0);
    $display("test duty_6bit done");
    r11 = $random(seed);
    r6 = $random(seed);
    wr(adr[10], 8'h80, 4'h1, `TVP_RESP_OKAY);
    wr(adr[0], {2'b00, r11[13:8]}, 4'h1, `TVP_RESP_OKAY);
    wr(adr[1], r11[7:0], 4'h1, `TVP_RESP_OKAY);
    wr(adr[8], {2'b00, r6[13:8]}, 4'h1, `TVP_RESP_OKAY);
    wr(adr[9], r6[7:0], 4'h1, `TVP_RESP_OKAY);
    repeat (16400) @(posedge clk);
    meas(3'h1, 16'd16384, {2'b00, r6}, {2'b00, r11}, 1'b1);
    $display("test ratio_14bit done");
    finish_test();
  end
endmodule // tvp_pwm_bank_tb

bind tvp_pwm_bank tvp_pwm_bank_props #(.AW(AW)) u_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_axi_awvalid(i_axi_awvalid), .o_axi_awready(o_axi_awready), .i_axi_awaddr(i_axi_awaddr),
  .i_axi_wvalid(i_axi_wvalid), .o_axi_wready(o_axi_wready), .o_axi_bvalid(o_axi_bvalid),
  .i_axi_bready(i_axi_bready), .o_axi_bresp(o_axi_bresp), .i_axi_arvalid(i_axi_arvalid),
  .o_axi_arready(o_axi_arready), .i_axi_araddr(i_axi_araddr), .o_axi_rvalid(o_axi_rvalid),
  .i_axi_rready(i_axi_rready), .o_axi_rdata(o_axi_rdata), .o_axi_rresp(o_axi_rresp),
  .o_ch5_pwm(o_ch5_pwm));
